// [verilog/motor_interlock.sv]
`timescale 1ns/1ns
`include "mmc_defs.svh"
// ****************************************************************
// Multi-motor interlock and regular bypass sequencer
// ****************************************************************
module motor_interlock #(
   parameter int NT = 11,
   parameter int FBW = 12,
   parameter int FW = 16
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [NT-1:0] term_i,
   input wire logic [FBW-1:0] feedback_i,
   output logic [3:0] relay_o,
   output logic [3:0] inv_connect_o,
   output logic out_block_o,
   output logic [FW-1:0] freq_cmd_o,
   output logic bypass_active_o
);
   import mmc_pkg::*;

   localparam logic [3:0] BLOCK_CYC = 4'(`OUT_BLOCK_CYC);

   logic [`CTRL_WIDTH-1:0] ctrl_r;
   logic [2:0] stage_req_r;
   logic [31:0] func_a_r;
   logic [11:0] func_b_r;
   logic [43:0] term_func;
   logic [FBW-1:0] fb_max_r;
   logic [FW-1:0] freq_max_r;
   logic [31:0] rd_nxt;
   logic req;

   logic ilk_en;
   logic byp_en;
   acm_mode_t acm;
   logic [2:0] start_sel;
   logic [2:0] aux_cnt;
   logic exp_present;
   logic run_en;

   logic [NT-1:0] term_q;
   logic [3:0] ilk_act;
   logic [3:0] avail;
   logic [2:0] byp_cnt;
   logic [FW-1:0] byp_freq;
   logic [2:0] want;
   logic [1:0] start_idx;
   logic [2:0] pool;
   logic [1:0] inv_r;
   logic [1:0] next_inv;
   logic next_ok;
   logic [3:0] blk_cnt_r;
   logic run_d_r;
   seq_state_t state_r;
   logic [3:0] pick_mask;

   // ****************************************************************
   // Helpers
   // ****************************************************************

   // Byte-lane merge for Wishbone sel
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // True when a terminal function code selects interlock k (0-based)
   function automatic logic is_ilk(input logic [3:0] code,
                                   input logic [1:0] k);
      return code == (`FUNC_ILK_BASE + {2'h0, k});
   endfunction

   // Walk the circular order from start, taking the first healthy motors
   function automatic logic [3:0] pick(input logic [1:0] start,
                                       input logic [2:0] pl,
                                       input logic [3:0] ok,
                                       input logic [2:0] n);
      logic [3:0] m;
      logic [2:0] idx;
      logic [2:0] taken;
      m = 4'h0;
      taken = 3'h0;
      idx = 3'h0;
      for (int i = 0; i < 4; i++) begin
         idx = {1'b0, start} + 3'(i);
         if (idx >= pl) begin
            idx = idx - pl;
         end
         if (3'(i) < pl && ok[idx[1:0]] && taken < n) begin
            m[idx[1:0]] = 1'b1;
            taken = taken + 3'h1;
         end
      end
      return m;
   endfunction

   // ****************************************************************
   // Wishbone slave
   // ****************************************************************
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;

   // Ack one cycle after the request, dropped the cycle after
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   // Register writes; unmapped or read-only offsets ignore data
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl_r <= `CTRL_RESET;
         stage_req_r <= `STAGE_REQ_RESET;
         func_a_r <= `TERM_FUNC_A_RESET;
         func_b_r <= `TERM_FUNC_B_RESET;
         fb_max_r <= `FB_MAX_RESET;
         freq_max_r <= `FREQ_MAX_RESET;
      end else if (req && wb_we_i) begin
         case (wb_adr_i)
            `REG_CTRL: ctrl_r <= `CTRL_WIDTH'(merge(
               {20'h0, ctrl_r}, wb_dat_i, wb_sel_i));
            `REG_STAGE_REQ: stage_req_r <= 3'(merge(
               {29'h0, stage_req_r}, wb_dat_i, wb_sel_i));
            `REG_TERM_FUNC_A: func_a_r <= merge(func_a_r, wb_dat_i,
               wb_sel_i);
            `REG_TERM_FUNC_B: func_b_r <= 12'(merge(
               {20'h0, func_b_r}, wb_dat_i, wb_sel_i));
            `REG_FB_MAX: fb_max_r <= FBW'(merge(
               {{(32-FBW){1'b0}}, fb_max_r}, wb_dat_i, wb_sel_i));
            `REG_FREQ_MAX: freq_max_r <= FW'(merge(
               {{(32-FW){1'b0}}, freq_max_r}, wb_dat_i, wb_sel_i));
            default: ;
         endcase
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      case (wb_adr_i)
         `REG_CTRL: rd_nxt = {20'h0, ctrl_r};
         `REG_STAGE_REQ: rd_nxt = {29'h0, stage_req_r};
         `REG_TERM_FUNC_A: rd_nxt = func_a_r;
         `REG_TERM_FUNC_B: rd_nxt = {20'h0, func_b_r};
         `REG_FB_MAX: rd_nxt = {{(32-FBW){1'b0}}, fb_max_r};
         `REG_FREQ_MAX: rd_nxt = {{(32-FW){1'b0}}, freq_max_r};
         `REG_STATUS: rd_nxt = {18'h0, state_r, bypass_active_o,
                                ilk_act, inv_r, relay_o};
         `REG_FREQ_CMD: rd_nxt = {{(32-FW){1'b0}}, freq_cmd_o};
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   // Read data held in a flop, valid with ack
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (req) begin
         wb_dat_o <= rd_nxt;
      end
   end

   // ****************************************************************
   // Control fields
   // ****************************************************************
   assign ilk_en = ctrl_r[`CTRL_ILK_EN];
   assign byp_en = ctrl_r[`CTRL_BYPASS_EN];
   assign acm = acm_mode_t'(ctrl_r[`CTRL_ACM_LSB +: 2]);
   assign start_sel = ctrl_r[`CTRL_START_LSB +: 3];
   assign aux_cnt = ctrl_r[`CTRL_COUNT_LSB +: 3];
   assign exp_present = ctrl_r[`CTRL_EXP_PRESENT];
   assign run_en = ctrl_r[`CTRL_RUN_EN];

   // ****************************************************************
   // Interlock inputs
   // ****************************************************************
   pin_sync3 #(
      .W(NT)
   ) u_sync (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .pin_i(term_i),
      .level_o(term_q)
   );

   // All terminal function codes as one vector, four bits per terminal
   assign term_func = {func_b_r, func_a_r};

   // Any terminal set to interlock k drives it; expansion slots need
   // the module present. Interlock k always maps to output slot k.
   always_comb begin
      ilk_act = 4'h0;
      for (int t = 0; t < NT; t++) begin
         for (int k = 0; k < 4; k++) begin
            if (term_q[t] && (t < `BASE_TERMINALS || exp_present) &&
                is_ilk(term_func[t*4 +: 4], 2'(k))) begin
               ilk_act[k] = 1'b1;
            end
         end
      end
   end

   // Disabled interlocks leave every motor available
   assign avail = ilk_en ? ~ilk_act : 4'hF;

   // ****************************************************************
   // Regular bypass
   // ****************************************************************
   bypass_stage #(
      .FBW(FBW),
      .FW(FW)
   ) u_bypass (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .feedback_i(feedback_i),
      .fb_max_i(fb_max_r),
      .freq_max_i(freq_max_r),
      .aux_count_i(aux_cnt),
      .stage_cnt_o(byp_cnt),
      .freq_o(byp_freq)
   );

   // Bypass overrides the externally requested stage count
   assign want = byp_en ? byp_cnt : stage_req_r;

   // ****************************************************************
   // Sequencing order
   // ****************************************************************

   // Selection of 0 is treated as 1 so the order always has a head
   assign start_idx = (start_sel == 3'h0) ? 2'h0 : 2'(start_sel - 3'h1);

   // Main mode pools the inverter motor with the auxiliaries; capped at 4
   always_comb begin
      if (acm == ACM_MAIN) begin
         pool = (aux_cnt >= 3'h3) ? 3'h4 : aux_cnt + 3'h1;
      end else begin
         pool = (aux_cnt > 3'h4) ? 3'h4 : aux_cnt;
      end
   end

   // Next healthy motor after the faulted inverter motor
   always_comb begin
      logic [2:0] idx;
      idx = 3'h0;
      next_inv = inv_r;
      next_ok = 1'b0;
      for (int i = 3; i >= 1; i--) begin
         idx = {1'b0, inv_r} + 3'(i);
         if (idx >= pool) begin
            idx = idx - pool;
         end
         if (3'(i) < pool && avail[idx[1:0]]) begin
            next_inv = idx[1:0];
            next_ok = 1'b1;
         end
      end
   end

   // Aux order follows the mode; main mode starts after the inverter
   // motor, so a recovered former inverter motor lands at the end
   always_comb begin
      if (acm == ACM_MAIN) begin
         pick_mask = pick(2'((({1'b0, inv_r} + 3'h1) >= pool) ?
                            3'h0 : {1'b0, inv_r} + 3'h1),
                          pool, avail & ~(4'h1 << inv_r),
                          want);
      end else begin
         pick_mask = pick(start_idx, pool, avail, want);
      end
   end

   // ****************************************************************
   // Inverter output state machine
   // ****************************************************************

   // A faulted inverter motor blocks the output for a short dead time
   // before the next motor is connected, so two never share it
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_r <= ST_RUN;
         inv_r <= 2'h0;
         blk_cnt_r <= 4'h0;
         run_d_r <= 1'b0;
      end else begin
         run_d_r <= run_en;
         case (state_r)
            ST_RUN: begin
               if (run_en && !run_d_r) begin
                  inv_r <= start_idx;
               end else if (acm == ACM_MAIN && run_en &&
                            !avail[inv_r]) begin
                  state_r <= ST_BLOCK;
                  blk_cnt_r <= BLOCK_CYC - 4'h1;
               end
            end
            ST_BLOCK: begin
               if (blk_cnt_r == 4'h0) begin
                  state_r <= ST_SWITCH;
               end else begin
                  blk_cnt_r <= blk_cnt_r - 4'h1;
               end
            end
            ST_SWITCH: begin
               // Stays blocked while no healthy motor is left
               if (next_ok) begin
                  inv_r <= next_inv;
                  state_r <= ST_RUN;
               end
            end
            default: state_r <= ST_RUN;
         endcase
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************

   // Relays follow the picked set: faulted motors drop, substitutes run,
   // and outside main mode release restores the original order
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         relay_o <= 4'h0;
      end else begin
         relay_o <= run_en ? pick_mask : 4'h0;
      end
   end

   // Inverter connection and output block
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         inv_connect_o <= 4'h0;
         out_block_o <= 1'b0;
      end else begin
         inv_connect_o <= (acm == ACM_MAIN && run_en &&
                           state_r == ST_RUN && avail[inv_r]) ?
                          (4'h1 << inv_r) : 4'h0;
         out_block_o <= (state_r != ST_RUN) ||
                        (acm == ACM_MAIN && run_en && !avail[inv_r]);
      end
   end

   // Speed command only meaningful in bypass; PID owns it otherwise
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         freq_cmd_o <= '0;
         bypass_active_o <= 1'b0;
      end else begin
         freq_cmd_o <= (byp_en && run_en) ? byp_freq : '0;
         bypass_active_o <= byp_en && run_en;
      end
   end

endmodule // motor_interlock

// [verilog/mmc_defs.svh]
`ifndef MMC_DEFS_SVH
`define MMC_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define REG_CTRL 8'h00
`define REG_STAGE_REQ 8'h04
`define REG_TERM_FUNC_A 8'h08
`define REG_TERM_FUNC_B 8'h0C
`define REG_FB_MAX 8'h10
`define REG_FREQ_MAX 8'h14
`define REG_STATUS 8'h18
`define REG_FREQ_CMD 8'h1C

// ****************************************************************
// Control register fields
// ****************************************************************
`define CTRL_ILK_EN 0
`define CTRL_BYPASS_EN 1
`define CTRL_ACM_LSB 2
`define CTRL_START_LSB 4
`define CTRL_COUNT_LSB 7
`define CTRL_EXP_PRESENT 10
`define CTRL_RUN_EN 11
`define CTRL_WIDTH 12

// ****************************************************************
// Reset values
// ****************************************************************
`define CTRL_RESET 12'h010
`define STAGE_REQ_RESET 3'h0
`define TERM_FUNC_A_RESET 32'h0000_0000
`define TERM_FUNC_B_RESET 12'h000
`define FB_MAX_RESET 12'hFFF
`define FREQ_MAX_RESET 16'h1770

// ****************************************************************
// Terminal function codes and timing
// ****************************************************************
`define FUNC_ILK_BASE 4'h1
`define BASE_TERMINALS 8
`define CLK_PERIOD_NS 100
`define OUT_BLOCK_NS 1000
`define OUT_BLOCK_CYC ((`OUT_BLOCK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [verilog/mmc_pkg.sv]
package mmc_pkg;

   // Auto change mode as written by software
   typedef enum logic [1:0] {
      ACM_NONE = 2'h0,
      ACM_AUX = 2'h1,
      ACM_MAIN = 2'h2
   } acm_mode_t;

   // Inverter output handling
   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_BLOCK = 3'b010,
      ST_SWITCH = 3'b100
   } seq_state_t;

endpackage

// [verilog/pin_sync3.sv]
`timescale 1ns/1ns
// ****************************************************************
// Three-stage pin synchroniser with agreement filter
// ****************************************************************
module pin_sync3 #(
   parameter int W = 11
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] level_o
);

   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   // Stage one feeds stage two only, so metastability stays contained
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= pin_i;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // A bit is accepted once stages two and three agree
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge ref_clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               level_o[g] <= 1'b0;
            end else if (s2_r[g] == s3_r[g]) begin
               level_o[g] <= s3_r[g];
            end
         end
      end
   endgenerate

endmodule // pin_sync3

// [verilog/bypass_stage.sv]
`timescale 1ns/1ns
// ****************************************************************
// Regular bypass: staging and speed straight from feedback
// ****************************************************************
module bypass_stage #(
   parameter int FBW = 12,
   parameter int FW = 16
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic [FBW-1:0] feedback_i,
   input wire logic [FBW-1:0] fb_max_i,
   input wire logic [FW-1:0] freq_max_i,
   input wire logic [2:0] aux_count_i,
   output logic [2:0] stage_cnt_o,
   output logic [FW-1:0] freq_o
);

   logic [2:0] cnt_nxt;
   logic [FW-1:0] freq_nxt;
   logic [FBW+FW-1:0] prod;

   // Motor n runs while fb*count >= n*max; below it the motor drops out
   always_comb begin
      cnt_nxt = 3'h0;
      for (int n = 1; n <= 4; n++) begin
         if (3'(n) <= aux_count_i && fb_max_i != '0 &&
             ({3'h0, feedback_i} * {{FBW{1'b0}}, aux_count_i}) >=
             ({3'h0, fb_max_i} * {{FBW{1'b0}}, 3'(n)})) begin
            cnt_nxt = cnt_nxt + 3'h1;
         end
      end
   end

   // Linear speed; feedback above its maximum clamps to full speed
   always_comb begin
      prod = {{FW{1'b0}}, feedback_i} * {{FBW{1'b0}}, freq_max_i};
      if (fb_max_i == '0) begin
         freq_nxt = '0;
      end else if (feedback_i >= fb_max_i) begin
         freq_nxt = freq_max_i;
      end else begin
         freq_nxt = FW'(prod / {{FW{1'b0}}, fb_max_i});
      end
   end

   // Outputs registered
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         stage_cnt_o <= 3'h0;
         freq_o <= '0;
      end else begin
         stage_cnt_o <= cnt_nxt;
         freq_o <= freq_nxt;
      end
   end

endmodule // bypass_stage

// [tb/motor_interlock_checker.sv]
`timescale 1ns/1ns
// ****************************************************************
// Port-level timing checks for the interlock sequencer
// ****************************************************************
module motor_interlock_checker #(
   parameter int NT = 11,
   parameter int FBW = 12,
   parameter int FW = 16
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [FBW-1:0] feedback_i,
   input wire logic [3:0] relay_o,
   input wire logic [3:0] inv_connect_o,
   input wire logic out_block_o,
   input wire logic [FW-1:0] freq_cmd_o,
   input wire logic bypass_active_o
);
   // One clock domain, so clock and reset are given once here
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   // Bus answer comes one cycle after the taken edge and lasts one cycle
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   // Holes in the map read as zero
   a_unmapped_zero: assert property (wb_cyc_i && wb_stb_i && !wb_we_i &&
      !wb_ack_o && wb_adr_i >= 8'h20 |=> wb_dat_o == 32'h0000_0000)
      else $error("unmapped read not zero");
   // Dead time on the inverter output, then a new motor is connected
   a_block_length: assert property ($rose(out_block_o) |->
      out_block_o [*8] ##1 out_block_o [*4] ##1 !out_block_o)
      else $error("output block length wrong");
   a_inv_onehot: assert property ($onehot0(inv_connect_o))
      else $error("two motors on inverter output");
   a_inv_after_block: assert property ($fell(out_block_o) |->
      ##[0:2] $onehot(inv_connect_o))
      else $error("no motor connected after block");
   // Speed command exists only while bypass runs
   a_freq_idle: assert property (!bypass_active_o && $past(!bypass_active_o)
      |-> freq_cmd_o == '0)
      else $error("speed command while bypass idle");
   a_bypass_zero: assert property ((bypass_active_o && feedback_i == '0) [*8]
      |-> relay_o == 4'h0 && freq_cmd_o == '0)
      else $error("motors staged at zero feedback");
endmodule // motor_interlock_checker

bind motor_interlock motor_interlock_checker #(.NT(NT), .FBW(FBW), .FW(FW))
   chk_i (.ref_clk_i, .resetn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_dat_o, .wb_ack_o, .feedback_i, .relay_o, .inv_connect_o, .out_block_o,
   .freq_cmd_o, .bypass_active_o);

// [tb/motor_fault_model.sv]
`timescale 1ns/1ns
// ****************************************************************
// Motor fault sense wiring seen at the input terminals
// ****************************************************************
module motor_fault_model #(
   parameter int DLY = 2
) (
   input wire logic ref_clk_i,
   input wire logic [3:0] fault_i,
   output logic [10:0] term_o
);
   logic [DLY*4-1:0] sense_r;
   logic [3:0] f;

   // Contact settling delay; a fault stays asserted while the motor is down
   always_ff @(posedge ref_clk_i) begin
      sense_r <= {sense_r[DLY*4-5:0], fault_i};
   end
   assign f = sense_r[DLY*4-1 -: 4];
   // Motors 1-3 on terminals 0-2, motor 4 only on the expansion terminal 8
   assign term_o = {2'h0, f[3], 5'h00, f[2:0]};
endmodule // motor_fault_model

// [tb/motor_interlock_tb.sv]
`timescale 1ns/1ns
// ****************************************************************
// Bench for the interlock sequencer
// ****************************************************************
module motor_interlock_tb;
   logic ref_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, blk, byp;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000, wb_dat, rdat;
   logic [3:0] fault = 4'h0, relay, inv;
   logic [11:0] fb = 12'h000;
   logic [10:0] term;
   logic [15:0] freq;
   int err_count = 0, n_tests = 0, cycles = 0, n, f;
   localparam int LIMIT = 5000;
   // Control words: aux/none/no-interlock/no-expansion/start 2
   logic [31:0] cr [10] = '{32'hE15, 32'hE15, 32'hE15, 32'hE15, 32'hE15,
      32'hE11, 32'hE14, 32'hE15, 32'hA15, 32'hE25};
   logic [2:0] st [10] = '{3'h3, 3'h3, 3'h3, 3'h2, 3'h3, 3'h3, 3'h3, 3'h4,
      3'h4, 3'h1};
   logic [3:0] fl [10] = '{4'h0, 4'h4, 4'h0, 4'h4, 4'h4, 4'h4, 4'h4, 4'h8,
      4'h8, 4'h0};
   logic [3:0] ex [10] = '{4'h7, 4'hB, 4'h7, 4'h3, 4'hB, 4'hB, 4'h7, 4'h7,
      4'hF, 4'h2};
   int fbv [8] = '{0, 'h0FF, 'h100, 'h200, 'h3FF, 'h400, 'h7FF, 'h1FF};

   initial forever #50 ref_clk_i = ~ref_clk_i;

   motor_fault_model fm (.ref_clk_i(ref_clk_i), .fault_i(fault), .term_o(term));
   motor_interlock dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wb_dat), .wb_ack_o(ack),
      .term_i(term), .feedback_i(fb), .relay_o(relay), .inv_connect_o(inv),
      .out_block_o(blk), .freq_cmd_o(freq), .bypass_active_o(byp));

   // ****************************************************************
   // Bus tasks and checks
   // ****************************************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Request held until ack is sampled, then released for a cycle
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      adr <= a;
      wdat <= d;
      we <= w;
      cyc <= 1'b1;
      stb <= 1'b1;
      do @(posedge ref_clk_i); while (ack !== 1'b1);
      rdat = wb_dat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge ref_clk_i);
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Hang guard
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == LIMIT) begin
         err_count++;
         stop_test();
      end
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      repeat (8) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      @(posedge ref_clk_i);
      bus(1'b0, 8'h00, 32'h0); chk("ctrl", 32'h010, rdat);
      bus(1'b0, 8'h10, 32'h0); chk("fbmax", 32'hFFF, rdat);
      bus(1'b0, 8'h14, 32'h0); chk("fmax", 32'h1770, rdat);
      bus(1'b0, 8'h20, 32'h0); chk("hole", 32'h0, rdat);
      // Interlocks 1-3 on terminals 0-2, interlock 4 on terminal 8
      bus(1'b1, 8'h08, 32'h0000_0321);
      bus(1'b1, 8'h0C, 32'h0000_0004);
      for (int i = 0; i < 10; i++) begin
         fault <= fl[i];
         bus(1'b1, 8'h00, cr[i]);
         bus(1'b1, 8'h04, {29'h0, st[i]});
         repeat (12) @(posedge ref_clk_i);
         chk("relay", {28'h0, ex[i]}, {28'h0, relay});
      end
      // Main mode, four motors, inverter starts on motor 1
      bus(1'b1, 8'h00, 32'h199);
      bus(1'b1, 8'h04, 32'h2);
      bus(1'b1, 8'h00, 32'h999);
      repeat (12) @(posedge ref_clk_i);
      chk("inv", 32'h1, {28'h0, inv});
      chk("relay", 32'h6, {28'h0, relay});
      fault <= 4'h1;
      repeat (9) @(posedge ref_clk_i);
      chk("block", 32'h1, {31'h0, blk});
      repeat (16) @(posedge ref_clk_i);
      chk("inv", 32'h2, {28'h0, inv});
      chk("relay", 32'hC, {28'h0, relay});
      fault <= 4'h0;
      bus(1'b1, 8'h04, 32'h3);
      repeat (12) @(posedge ref_clk_i);
      chk("relay", 32'hD, {28'h0, relay});
      // Bypass: four aux motors, thresholds at quarters of 0x400
      bus(1'b1, 8'h10, 32'h400);
      bus(1'b1, 8'h00, 32'hA16);
      for (int i = 0; i < 8; i++) begin
         fb <= fbv[i][11:0];
         repeat (12) @(posedge ref_clk_i);
         n = (fbv[i] * 4) / 1024;
         if (n > 4) n = 4;
         f = (fbv[i] * 6000) / 1024;
         if (f > 6000) f = 6000;
         chk("relay", (1 << n) - 1, {28'h0, relay});
         chk("freq", f, {16'h0, freq});
         chk("active", 32'h1, {31'h0, byp});
      end
      bus(1'b0, 8'h1C, 32'h0); chk("freqreg", f, rdat);
      bus(1'b1, 8'h00, 32'h216);
      repeat (12) @(posedge ref_clk_i);
      chk("freq", 32'h0, {16'h0, freq});
      stop_test();
   end
endmodule // motor_interlock_tb
